// ### verilog/ccpwm_pkg.sv
// Constants, types and decode helpers shared by the capture/compare/PWM unit.
// Functional notes
// - Capture copies full 16-bit timer into register pair.
// - Mode picks falling, rising, 4th or 16th rise.
// - Every capture sets flag bit 2.
// - A new capture overwrites the old value.
// - Edges act on pin level, even driven.
// - Prescaler cleared when off, not capturing, reset.
// - Switching prescalers keeps the counter running.
// - Compare register pair against timer every cycle.
// - Match drives pin per mode, sets flag.
// - Writing zero control forces output latch low.
// - Software-interrupt compare sets flag, pin untouched.
// - Special event clears timer, starts enabled conversion.
// - Special event never sets the overflow flag.
// - Period end clears timer, sets pin unless duty is zero, loads duty.
// - Postscaler plays no part in PWM timing.
// - Duty is low byte plus control bits 5:4.
// - Duty writes act next period; high byte read-only.
// - Duty double buffered in high byte plus latch.
// - Pin clears when duty equals extended period timer.
// - Duty beyond period keeps the pin high.
package ccpwm_pkg;

  localparam int ADDR_W = 10;  // APB byte address width.
  localparam int DATA_W = 32;  // APB data width.

  // Register indexes; the byte address is four times the index.
  localparam logic [7:0] IDX_CAP_LOW  = 8'h15;
  localparam logic [7:0] IDX_CAP_HIGH = 8'h16;
  localparam logic [7:0] IDX_CTRL     = 8'h17;
  localparam logic [7:0] IDX_FLAG     = 8'h18;

  // Field positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DUTY_LSB = 4;
  localparam int FLAG_BIT      = 2;

  // Reset values.
  localparam logic [7:0] CAP_RST  = 8'h00;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // Mode field encodings; any code with both top bits set is PWM.
  localparam logic [3:0] MODE_OFF       = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL  = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE  = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET   = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR   = 4'h9;
  localparam logic [3:0] MODE_CMP_SWINT = 4'hA;
  localparam logic [3:0] MODE_CMP_SPEC  = 4'hB;

  // Prescaler counts at which the 4th and 16th rising edges fall.
  localparam logic [1:0] PSC_LAST4  = 2'h3;
  localparam logic [3:0] PSC_LAST16 = 4'hF;

  // Timer values that arrive from the two outside timers.
  typedef struct packed {
    logic [15:0] capture_count;  // Capture timer count.
    logic [7:0]  period_count;   // Period timer count.
    logic [7:0]  period_value;   // Period register value.
    logic [1:0]  fine_phase;     // Phase clock or prescaler low bits.
  } ccpwm_timers_s;

  // Control register fields.
  typedef struct packed {
    logic [1:0] duty_lsb;  // Two low duty bits.
    logic [3:0] mode;      // Unit mode field.
  } ccpwm_ctrl_s;

  // Broad operating state decoded from the mode field.
  typedef enum logic [1:0] {
    OP_OFF,
    OP_CAPTURE,
    OP_COMPARE,
    OP_PWM
  } ccpwm_op_e;

  // Decode the mode field into the broad operating state.
  function automatic ccpwm_op_e ccpwm_decode(input logic [3:0] mode);
    case (mode[3:2])
      2'h1:    ccpwm_decode = OP_CAPTURE;
      2'h2:    ccpwm_decode = OP_COMPARE;
      2'h3:    ccpwm_decode = OP_PWM;
      default: ccpwm_decode = (mode == MODE_OFF) ? OP_OFF : OP_OFF;
    endcase
  endfunction

endpackage

// ### verilog/ccpwm_sync.sv
// Two-stage synchroniser for a single asynchronous level.
`timescale 1ns/1ns
module ccpwm_sync
  import ccpwm_pkg::*;
(
  input  wire logic i_ref_clk,  // System clock.
  input  wire logic i_resetn,   // Synchronous reset, active low.
  input  wire logic i_async,    // Level from outside the clock domain.
  output logic      o_sync      // Level safe to use in the clock domain.
);

  logic meta_reg;  // First stage; only the second stage reads it.
  logic sync_reg;  // Second stage.

  // Two flops give a metastable first stage a full cycle to settle.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule

// ### verilog/ccpwm_top.sv
// Capture/compare/PWM unit with an APB register slave.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
module ccpwm_top
  import ccpwm_pkg::*;
(
  input  wire logic              i_ref_clk,        // System clock, 100 MHz.
  input  wire logic              i_resetn,         // Synchronous reset, active low.
  input  wire logic              i_psel,           // APB select.
  input  wire logic              i_penable,        // APB access phase.
  input  wire logic              i_pwrite,         // APB write direction.
  input  wire logic [ADDR_W-1:0] i_paddr,          // APB byte address.
  input  wire logic [DATA_W-1:0] i_pwdata,         // APB write data.
  output logic      [DATA_W-1:0] o_prdata,         // APB read data.
  output logic                   o_pready,         // APB ready.
  output logic                   o_pslverr,        // APB error for unmapped address.
  input  wire logic              i_pin,            // Unit pin level from the pad.
  input  wire ccpwm_timers_s     i_timers,         // Timer counts from outside.
  input  wire logic              i_period_inc,     // Period timer increments now.
  input  wire logic              i_adc_enable,     // Converter is enabled.
  output logic                   o_pin_out,        // Compare/PWM output latch.
  output logic                   o_cap_timer_clr,  // Special event trigger.
  output logic                   o_adc_start,      // Conversion request.
  output logic                   o_period_clr,     // Period timer clear.
  output logic                   o_unit_flag       // Unit interrupt flag.
);

  // Register state.
  logic [7:0]  cap_low_reg;     // Capture register low byte.
  logic [7:0]  cap_high_reg;    // Capture register high byte.
  ccpwm_ctrl_s ctrl_reg;        // Control register.
  logic        flag_reg;        // Sticky interrupt flag.
  logic [1:0]  duty_lat_reg;    // Internal 2-bit duty latch.
  logic        pin_reg;         // Output latch.
  logic        pin_d_reg;       // Delayed synchronised pin.
  logic [3:0]  psc_reg;         // Capture prescaler counter.
  logic        match_d_reg;     // Compare match of the previous cycle.
  logic        pready_reg;      // Registered ready.
  logic        pslverr_reg;     // Registered error.
  logic [DATA_W-1:0] prdata_reg; // Registered read data.
  logic        tclr_reg;        // Registered special event.
  logic        adc_reg;         // Registered conversion request.
  logic        pclr_reg;        // Registered period clear.

  // Combinational helpers.
  ccpwm_op_e   op;              // Broad operating state.
  logic        pin_s;           // Synchronised pin level.
  logic        rise;            // Rising edge seen on the pin.
  logic        fall;            // Falling edge seen on the pin.
  logic        cap_event;       // Capture qualifies this cycle.
  logic        match;           // Compare equality this cycle.
  logic        cmp_event;       // First cycle of a match.
  logic        period_end;      // PWM period completes now.
  logic        duty_hit;        // Active duty meets the time base.
  logic [9:0]  duty_next;       // Duty value to be latched.
  logic        setup;           // APB setup cycle.
  logic        wr_fire;         // APB write takes effect.
  logic [7:0]  word_idx;        // Addressed register index.
  logic        mapped;          // Address holds a register.
  logic [DATA_W-1:0] rd_mux;    // Read data for the addressed register.
  logic        wr_low;          // Write to the low byte.
  logic        wr_high;         // Write to the high byte.
  logic        wr_ctrl;         // Write to the control register.
  logic        wr_flag;         // Write to the flag register.
  logic        flag_clr;        // Software clears the flag.

  assign op = ccpwm_decode(ctrl_reg.mode);

  // The pad level is sampled whatever the port direction.
  ccpwm_sync u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_async   (i_pin),
    .o_sync    (pin_s)
  );

  // Edge history; reads only the settled second stage.
  // It resets to the idle low level of the pad, so release gives no false edge.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      pin_d_reg <= 1'b0;
    end else begin
      pin_d_reg <= pin_s;
    end
  end

  assign rise = pin_s & ~pin_d_reg;
  assign fall = ~pin_s & pin_d_reg;

  // APB decode; an access completes in its second cycle.
  // A write also needs ready from this slave, so a stray access phase writes nothing.
  assign setup    = i_psel & ~i_penable;
  assign wr_fire  = i_psel & i_penable & pready_reg & i_pwrite;
  assign word_idx = i_paddr[9:2];
  assign wr_low   = wr_fire && (word_idx == IDX_CAP_LOW);
  assign wr_high  = wr_fire && (word_idx == IDX_CAP_HIGH);
  assign wr_ctrl  = wr_fire && (word_idx == IDX_CTRL);
  assign wr_flag  = wr_fire && (word_idx == IDX_FLAG);
  assign flag_clr = wr_flag & i_pwdata[FLAG_BIT];

  // Read multiplexer; narrow registers sit in the low bits.
  // Unused upper bits read as zero, which software may rely on.
  always_comb begin
    rd_mux = '0;
    mapped = 1'b1;
    case (word_idx)
      IDX_CAP_LOW:  rd_mux[7:0] = cap_low_reg;
      IDX_CAP_HIGH: rd_mux[7:0] = cap_high_reg;
      IDX_CTRL:     rd_mux[5:0] = ctrl_reg;
      IDX_FLAG:     rd_mux[FLAG_BIT] = flag_reg;
      default:      mapped = 1'b0;
    endcase
  end

  // Ready rises one cycle after setup, so every access takes two cycles.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else if (setup) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= ~mapped;
      prdata_reg  <= i_pwrite ? '0 : rd_mux;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // Capture prescaler; mode switches inside capture leave it counting.
  // It also counts in falling-edge mode, where its value is simply unused.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      psc_reg <= 4'h0;
    end else if (op != OP_CAPTURE) begin
      psc_reg <= 4'h0;
    end else if (rise) begin
      psc_reg <= psc_reg + 4'h1;
    end
  end

  // Capture event selection by mode.
  // Modes 1 to 3 and every non-capture mode take the default and never capture.
  always_comb begin
    case (ctrl_reg.mode)
      MODE_CAP_FALL:   cap_event = fall;
      MODE_CAP_RISE:   cap_event = rise;
      MODE_CAP_RISE4:  cap_event = rise && (psc_reg[1:0] == PSC_LAST4);
      MODE_CAP_RISE16: cap_event = rise && (psc_reg == PSC_LAST16);
      default:         cap_event = 1'b0;
    endcase
  end

  // Equality is checked every cycle against the live timer count.
  // Compare runs every cycle; only the first matching cycle acts, so a
  // stopped timer does not re-trigger the pin or the special event.
  assign match     = (op == OP_COMPARE) &&
                     (i_timers.capture_count == {cap_high_reg, cap_low_reg});
  assign cmp_event = match & ~match_d_reg;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      match_d_reg <= 1'b0;
    end else begin
      match_d_reg <= match;
    end
  end

  // PWM time base; no postscaler input exists, so it cannot shape the period.
  assign period_end = (op == OP_PWM) && i_period_inc &&
                      (i_timers.period_count == i_timers.period_value);
  assign duty_next  = {cap_low_reg, ctrl_reg.duty_lsb};
  assign duty_hit   = ({cap_high_reg, duty_lat_reg} ==
                       {i_timers.period_count, i_timers.fine_phase});

  // Capture register pair; a capture beats a software write.
  // A low byte write during PWM only changes the duty of the next period.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      cap_low_reg  <= CAP_RST;
      cap_high_reg <= CAP_RST;
    end else if (cap_event) begin
      cap_low_reg  <= i_timers.capture_count[7:0];
      cap_high_reg <= i_timers.capture_count[15:8];
    end else begin
      if (wr_low) begin
        cap_low_reg <= i_pwdata[7:0];
      end
      if (period_end) begin
        cap_high_reg <= cap_low_reg;
      end else if (wr_high && (op != OP_PWM)) begin
        cap_high_reg <= i_pwdata[7:0];
      end
    end
  end

  // Second half of the duty buffer, loaded with the high byte.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      duty_lat_reg <= 2'h0;
    end else if (period_end) begin
      duty_lat_reg <= ctrl_reg.duty_lsb;
    end
  end

  // Control register.
  // Only six bits exist; the upper bits of the write data are dropped.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= i_pwdata[5:0];
    end
  end

  // Sticky flag; a set in the clearing cycle wins so no event is lost.
  // Hardware has no clearing path of its own; only the write below clears it.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      flag_reg <= 1'b0;
    end else if (cap_event || cmp_event) begin
      flag_reg <= 1'b1;
    end else if (flag_clr) begin
      flag_reg <= 1'b0;
    end
  end

  // Output latch for compare and PWM.
  // Leaving compare or PWM keeps the latch; only a zero control write resets it.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      pin_reg <= 1'b0;
    end else if (wr_ctrl && (i_pwdata[5:0] == CTRL_RST)) begin
      pin_reg <= 1'b0;
    end else begin
      case (op)
        OP_COMPARE: begin
          if (cmp_event && (ctrl_reg.mode == MODE_CMP_SET)) begin
            pin_reg <= 1'b1;
          end else if (cmp_event && (ctrl_reg.mode == MODE_CMP_CLR)) begin
            pin_reg <= 1'b0;
          end
        end
        OP_PWM: begin
          // A duty above the period never hits, so the pin stays high.
          if (period_end) begin
            pin_reg <= (duty_next != 10'h000);
          end else if (duty_hit) begin
            pin_reg <= 1'b0;
          end
        end
        default: begin
          pin_reg <= pin_reg;
        end
      endcase
    end
  end

  // Trigger pulses toward the timers and the converter. The timer clear
  // is a separate line, so it can never reach the overflow flag.
  // The converter request is gated here, so a disabled converter sees no pulse.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      tclr_reg <= 1'b0;
      adc_reg  <= 1'b0;
      pclr_reg <= 1'b0;
    end else begin
      tclr_reg <= cmp_event && (ctrl_reg.mode == MODE_CMP_SPEC);
      adc_reg  <= cmp_event && (ctrl_reg.mode == MODE_CMP_SPEC) && i_adc_enable;
      pclr_reg <= period_end;
    end
  end

  assign o_prdata        = prdata_reg;
  assign o_pready        = pready_reg;
  assign o_pslverr       = pslverr_reg;
  assign o_pin_out       = pin_reg;
  assign o_cap_timer_clr = tclr_reg;
  assign o_adc_start     = adc_reg;
  assign o_period_clr    = pclr_reg;
  assign o_unit_flag     = flag_reg;

  // Checks of this side's rules; they are switched off during reset.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  a_flag_sticky: assert property (flag_reg && !flag_clr |=> flag_reg)
    else $error("flag dropped without software clear");
  a_capture_copy: assert property (cap_event |=>
    {cap_high_reg, cap_low_reg} == $past(i_timers.capture_count))
    else $error("capture did not copy timer");
  a_capture_flag: assert property (cap_event |=> flag_reg)
    else $error("capture did not set flag");
  a_psc_clear: assert property (op != OP_CAPTURE |=> psc_reg == 4'h0)
    else $error("prescaler not cleared");
  a_rise4_spacing: assert property (ctrl_reg.mode == MODE_CAP_RISE4 &&
    psc_reg[1:0] != PSC_LAST4 |-> !cap_event)
    else $error("capture off the 4th edge");
  a_cmp_set: assert property (cmp_event && ctrl_reg.mode == MODE_CMP_SET &&
    !wr_ctrl |=> pin_reg && flag_reg)
    else $error("compare set mode failed");
  a_swint_pin: assert property (cmp_event && ctrl_reg.mode == MODE_CMP_SWINT &&
    !wr_ctrl |=> $stable(pin_reg))
    else $error("software interrupt mode moved pin");
  a_special_trig: assert property (cmp_event &&
    ctrl_reg.mode == MODE_CMP_SPEC |=> o_cap_timer_clr ##1 !o_cap_timer_clr)
    else $error("special event pulse wrong");
  a_zero_ctrl: assert property (wr_ctrl && i_pwdata[5:0] == CTRL_RST |=> !o_pin_out)
    else $error("zero control left pin high");
  a_duty_load: assert property (period_end |=>
    {cap_high_reg, duty_lat_reg} == $past(duty_next) && o_period_clr)
    else $error("duty not loaded at period end");
  a_duty_clear: assert property (op == OP_PWM && duty_hit && !period_end &&
    !wr_ctrl |=> !pin_reg)
    else $error("pin not cleared at duty");
  a_high_ro: assert property (op == OP_PWM && !period_end && !cap_event |=>
    $stable(cap_high_reg))
    else $error("high byte changed mid period");

  // Further checks on the flag clear, the compare actions and the PWM edges.
  a_flag_clear: assert property (flag_clr && !cap_event && !cmp_event |=> !flag_reg)
    else $error("flag not cleared by software");
  a_cmp_clear: assert property (cmp_event && ctrl_reg.mode == MODE_CMP_CLR &&
    !wr_ctrl |=> !pin_reg && flag_reg)
    else $error("compare clear mode failed");
  a_special_adc: assert property (cmp_event && ctrl_reg.mode == MODE_CMP_SPEC &&
    i_adc_enable |=> o_adc_start)
    else $error("special event gave no conversion request");
  a_period_set: assert property (period_end && duty_next != 10'h000 && !wr_ctrl |=>
    pin_reg)
    else $error("pin not set at period end");
  a_zero_duty: assert property (period_end && duty_next == 10'h000 && !wr_ctrl |=>
    !pin_reg)
    else $error("zero duty set the pin");
  a_pwm_hold: assert property (op == OP_PWM && pin_reg && !duty_hit && !period_end &&
    !wr_ctrl |=> pin_reg)
    else $error("pin fell without a duty hit");

  c_capture: cover property (cap_event && ctrl_reg.mode == MODE_CAP_RISE16);
  c_special: cover property (cmp_event && ctrl_reg.mode == MODE_CMP_SPEC);
  c_pwm_cycle: cover property (period_end ##[1:300] duty_hit);
  c_flag_race: cover property (cap_event && flag_clr);
  c_pwm_full: cover property (period_end && duty_next > {i_timers.period_value, 2'h3});

endmodule

// ### tb/ccpwm_pin_src.sv
// Outside signal source model that drives the unit pin pad.
`timescale 1ns/1ns
module ccpwm_pin_src (
  input  wire logic i_ref_clk,  // System clock.
  output logic      o_pin       // Pad level seen by the unit.
);
  // The pad idles low, so a reset sees no edge.
  initial o_pin = 1'b0;

  // One high pulse with each level held for hold cycles.
  // Two cycles is the least that the synchroniser is sure to see.
  task automatic pulse(input int hold);
    @(posedge i_ref_clk);
    o_pin <= 1'b1;
    repeat (hold) @(posedge i_ref_clk);
    o_pin <= 1'b0;
    repeat (hold) @(posedge i_ref_clk);
  endtask
endmodule

// ### tb/tb_ccpwm_top.sv
// Self-checking bench for the capture/compare/PWM unit.
`timescale 1ns/1ns
module tb_ccpwm_top
  import ccpwm_pkg::*;
;
  localparam logic [7:0] PER      = 8'h05;               // Period register value.
  localparam int         PLEN     = 4 * (int'(PER) + 1); // Cycles in one period.
  localparam logic [3:0] CMP_MODE [6] = '{MODE_CMP_SET, MODE_CMP_SWINT, MODE_CMP_CLR,
                                          MODE_CMP_SPEC, MODE_CMP_SPEC, MODE_CMP_SET};
  localparam logic [5:0] CMP_PIN  = 6'h23;               // Pin level after each match.
  localparam logic [5:0] CMP_TRG  = 6'h18;               // Trigger expected per entry.
  localparam logic [5:0] CMP_ADC  = 6'h2F;               // Converter enable per entry.
  localparam logic [9:0] DUTY [3] = '{10'h000, 10'h00B, 10'h3FF};
  logic                ref_clk = 1'b0;    // System clock.
  logic                resetn  = 1'b0;    // Reset, active low.
  logic                psel    = 1'b0;    // APB select.
  logic                penable = 1'b0;    // APB access phase.
  logic                pwrite  = 1'b0;    // APB direction.
  logic [ADDR_W-1:0]   paddr   = '0;      // APB byte address.
  logic [DATA_W-1:0]   pwdata  = '0;      // APB write data.
  logic [DATA_W-1:0]   prdata;            // APB read data.
  logic                pready, pslverr;   // APB answer.
  logic                pin;               // Pad level from the source model.
  ccpwm_timers_s       tm = '0;           // Outside timer values.
  logic                period_inc = 1'b0; // Period timer tick.
  logic                adc_en = 1'b0;     // Converter enable.
  logic                pin_out, tmr_clr, adc_start, period_clr, unit_flag;
  logic [DATA_W:0]     exp_q [$];         // Expected {error, data} of each read.
  int                  miscompares = 0;   // Mismatches seen.
  int                  check_count = 0;   // Comparisons made.
  int                  cycles = 0;        // Clock cycles since start.
  int                  n, hi, e;          // Edge count, high time, expectation.
  logic [31:0]         rng = 32'h0000B244; // Random state.
  logic [31:0]         r, tgt;            // Random draws.
  logic [9:0]          duty;              // Duty under test.

  // Clock at 100 MHz.
  always #5 ref_clk = ~ref_clk;

  ccpwm_top i_dut (
    .i_ref_clk(ref_clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_pin(pin), .i_timers(tm),
    .i_period_inc(period_inc), .i_adc_enable(adc_en), .o_pin_out(pin_out),
    .o_cap_timer_clr(tmr_clr), .o_adc_start(adc_start), .o_period_clr(period_clr),
    .o_unit_flag(unit_flag));

  ccpwm_pin_src i_src (.i_ref_clk(ref_clk), .o_pin(pin));

  // Period timer stand-in: {count, phase} steps once a cycle and wraps after
  // the period value; a synchronous timer keeps capture reliable.
  always @(posedge ref_clk) begin
    tm.fine_phase <= tm.fine_phase + 2'h1;
    tm.period_value <= PER;
    period_inc <= (tm.fine_phase == 2'h2);
    if (period_inc) begin
      tm.period_count <= (tm.period_count == PER) ? 8'h00 : tm.period_count + 8'h01;
    end
  end

  // Xorshift source of random values.
  function automatic logic [31:0] next_rand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Compare one value and report a mismatch at once.
  task automatic chk(input logic [DATA_W:0] got, input logic [DATA_W:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // One APB transfer; a read notes its expected answer for the monitor.
  // The idle cycle in front keeps two calls from driving psel in one step.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                     input logic err);
    @(posedge ref_clk);
    if (!wr) exp_q.push_back({err, d});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read answers are taken at the sampling edge and matched to the oldest note.
  always @(posedge ref_clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // Print the counts and the verdict, then stop.
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hang is cut short well past the expected run length.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    // Reset values, then an unmapped place that must be refused.
    for (int i = 0; i < 4; i++) apb(1'b0, IDX_CAP_LOW + i[7:0], 32'h0, 1'b0);
    apb(1'b0, 8'h20, 32'h0, 1'b1);
    $display("test reset done");
    // Capture in every mode; earlier edges carry other counts, so a capture
    // on a wrong edge, or a missed overwrite, leaves the wrong value.
    for (int m = 0; m < 4; m++) begin
      n = (m < 2) ? 2 : (m == 2) ? 4 : 16;
      apb(1'b1, IDX_CTRL, 32'h0, 1'b0);
      apb(1'b1, IDX_CTRL, {28'h0, MODE_CAP_FALL + m[3:0]}, 1'b0);
      if (m == 2) begin
        // Two counted edges, then off: the count must start again.
        repeat (2) i_src.pulse(4);
        apb(1'b1, IDX_CTRL, 32'h0, 1'b0);
        apb(1'b1, IDX_CTRL, {28'h0, MODE_CAP_RISE4}, 1'b0);
      end
      for (int k = 0; k < n; k++) begin
        r = next_rand();
        tm.capture_count <= r[15:0];
        i_src.pulse(4 + 3 * (k % 2));
      end
      apb(1'b0, IDX_CAP_LOW, {24'h0, r[7:0]}, 1'b0);
      apb(1'b0, IDX_CAP_HIGH, {24'h0, r[15:8]}, 1'b0);
      apb(1'b0, IDX_FLAG, 32'h4, 1'b0);
      apb(1'b1, IDX_FLAG, 32'h4, 1'b0);
      apb(1'b0, IDX_FLAG, 32'h0, 1'b0);
      $display("test capture mode %0d done", m);
    end
    // Compare: each table entry gives the pin, trigger and converter result.
    tgt = next_rand();
    tm.capture_count <= tgt[15:0] + 16'h1;
    apb(1'b1, IDX_CTRL, 32'h0, 1'b0);
    apb(1'b1, IDX_CAP_LOW, {24'h0, tgt[7:0]}, 1'b0);
    apb(1'b1, IDX_CAP_HIGH, {24'h0, tgt[15:8]}, 1'b0);
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, IDX_CTRL, {28'h0, CMP_MODE[k]}, 1'b0);
      @(posedge ref_clk);
      tm.capture_count <= tgt[15:0];
      adc_en <= CMP_ADC[k];
      @(posedge ref_clk);
      tm.capture_count <= tgt[15:0] + 16'h1;
      #1;
      chk(pin_out, CMP_PIN[k]);
      chk(tmr_clr, CMP_TRG[k]);
      chk(adc_start, CMP_TRG[k] & CMP_ADC[k]);
      chk(unit_flag, 1'b1);
      @(posedge ref_clk);
      #1;
      chk(tmr_clr, 1'b0);
      apb(1'b1, IDX_FLAG, 32'h4, 1'b0);
    end
    apb(1'b1, IDX_CTRL, 32'h0, 1'b0);
    @(posedge ref_clk);
    #1;
    chk(pin_out, 1'b0);
    $display("test compare done");
    // PWM: zero duty, a mid duty and one beyond the period.
    for (int k = 0; k < 3; k++) begin
      duty = DUTY[k];
      apb(1'b1, IDX_CAP_LOW, {24'h0, duty[9:2]}, 1'b0);
      apb(1'b1, IDX_CTRL, {26'h0, duty[1:0], 4'hC}, 1'b0);
      apb(1'b1, IDX_CAP_HIGH, 32'h5A, 1'b0);
      @(posedge ref_clk);
      #1;
      while (period_clr !== 1'b1) begin
        @(posedge ref_clk);
        #1;
      end
      hi = 0;
      repeat (PLEN) begin
        hi += (pin_out === 1'b1);
        @(posedge ref_clk);
        #1;
      end
      e = (duty == 10'h000) ? 0 : (int'(duty) >= PLEN) ? PLEN : int'(duty) + 1;
      chk(33'(hi), 33'(e));
      apb(1'b0, IDX_CAP_HIGH, {24'h0, duty[9:2]}, 1'b0);
      $display("test pwm duty %0h done", duty);
    end
    final_report();
  end
endmodule
